// file: verilog/hdc_pkg.sv
// Constants shared by the hub downstream port control block.
// Assumes a 125 MHz core clock and a 32-bit classic Wishbone register bus.
package hdc_pkg;

  localparam int CLK_NS         = 8;
  // Overcurrent shutdown delay, least value of the 3 to 4 ms window
  localparam int OC_TIME_US     = 3000;
  // Downstream port reset length
  localparam int PRST_TIME_US   = 10000;
  localparam int OC_CYC_DEF     = (OC_TIME_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int PRST_CYC_DEF   = (PRST_TIME_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int TMR_W          = 21;
  localparam int NPORT          = 4;

  // Register byte offsets
  localparam logic [7:0] ADR_CTRL  = 8'h00;
  localparam logic [7:0] ADR_DEV   = 8'h04;
  localparam logic [7:0] ADR_CMD   = 8'h08;
  localparam logic [7:0] ADR_STAT  = 8'h0C;
  localparam logic [7:0] ADR_CHG   = 8'h10;
  localparam logic [7:0] ADR_LED   = 8'h14;
  localparam logic [7:0] ADR_HCHAR = 8'h18;

  // CTRL fields
  localparam int CTRL_SUSP = 0;
  localparam int CTRL_MTT  = 1;
  localparam int CTRL_MAN  = 2;
  // DEV fields
  localparam int DEV_CFG_LSB  = 8;
  // CMD fields
  localparam int CMD_PORT_LSB = 4;
  // STAT fields, one byte per port
  localparam int ST_POWER = 0;
  localparam int ST_CONN  = 1;
  localparam int ST_EN    = 2;
  localparam int ST_SUSP  = 3;
  localparam int ST_OC    = 4;
  localparam int ST_RST   = 5;
  localparam int ST_LS    = 6;
  localparam int ST_HS    = 7;
  localparam int ST_STRIDE = 8;
  // CHG fields, one byte per port
  localparam int CH_CONN = 0;
  localparam int CH_EN   = 1;
  localparam int CH_SUSP = 2;
  localparam int CH_OC   = 3;
  localparam int CH_RST  = 4;
  localparam int CHG_W   = 5;
  // Hub characteristics
  localparam int HCHAR_IND_BIT = 7;
  localparam int HCHAR_IND_PWR = 0;
  localparam int HCHAR_IND_OC  = 3;
  // LED manual codes, two bits per port
  localparam logic [1:0] LED_OFF   = 2'h0;
  localparam logic [1:0] LED_AMBER = 2'h1;
  localparam logic [1:0] LED_GREEN = 2'h2;

  typedef enum logic [2:0] {
    CMD_NONE   = 3'h0,
    CMD_SET_PWR = 3'h1,
    CMD_CLR_PWR = 3'h2,
    CMD_SET_RST = 3'h3,
    CMD_CLR_EN  = 3'h4,
    CMD_SET_SUS = 3'h5,
    CMD_CLR_SUS = 3'h6
  } hdc_cmd_t;

  typedef enum logic [2:0] {
    PS_OFF  = 3'h0,
    PS_DISC = 3'h1,
    PS_DIS  = 3'h2,
    PS_RST  = 3'h3,
    PS_EN   = 3'h4,
    PS_SUSP = 3'h5
  } hdc_pst_t;

endpackage

// file: verilog/hdc_port_ctrl.sv
// Downstream port control for a four-port USB 2.0 hub.
// Assumes the protocol engine hands over decoded hub requests as register
// writes, and gives eof2 and bus reset as one-cycle pulses on clk_i.
// Operation
// - Bus reset clears address and configuration value to zero.
// - Unconfigured hub drives SE0 on every port and keeps ports unpowered.
// - Configured hub releases ports; host powers each with SetPortPower.
// - Powered ports detect connect and disconnect; changes go to status endpoint.
// - SetPortReset on attached port: reset, then enable, then arm babble.
// - Non-idle, non-SE0 line after EOF2 on an enabled port is babble; disable it. SE0 there is a disconnect.
// - ClearPortEnable disables the addressed port.
// - SetPortSuspend and ClearPortSuspend act on the addressed port only.
// - Hub awake: remote wakeup shows as a port change indication.
// - Hub suspended: remote wakeup raises resume signalling upstream.
// - Overcurrent is reported and the port power enable is dropped.
// - Power enable drops 3 to 4 ms after overcurrent detection.
// - Ganged or individual power switching chosen by pin strap.
// - Power enable active level chosen by pin strap.
// - Hub characteristics bit 7 reports port indicators present.
// - Indicators have automatic and manual modes; automatic after power-up.
// - All indicators off while the hub is suspended.
// - Port routes through translator when speeds differ, else repeater.
// - Single translator mode after configuration; SetInterface selects multiple.
// - Single mode forwards full/low-speed traffic to all such ports.
// - Upstream transmitter blocks downstream babble and disconnect.
//
// Our own choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/100ps
module hdc_port_ctrl
  import hdc_pkg::*;
#(
  parameter int NP         = NPORT,
  parameter int OC_CYCLES  = OC_CYC_DEF,
  parameter int RST_CYCLES = PRST_CYC_DEF
) (
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  input  wire logic [7:0]    wb_adr_i,
  input  wire logic [31:0]   wb_dat_i,
  output      logic [31:0]   wb_dat_o,
  input  wire logic          wb_we_i,
  input  wire logic [3:0]    wb_sel_i,
  input  wire logic          wb_cyc_i,
  input  wire logic          wb_stb_i,
  output      logic          wb_ack_o,
  input  wire logic          usb_bus_reset_i,
  input  wire logic          eof2_i,
  input  wire logic          up_hs_i,
  input  wire logic [NP-1:0] port_hs_i,
  input  wire logic          rpt_up_active_i,
  input  wire logic [NP-1:0] tt_target_i,
  input  wire logic [NP-1:0] port_dp_i,
  input  wire logic [NP-1:0] port_dm_i,
  input  wire logic [NP-1:0] port_overcurrent_in_n_i,
  input  wire logic          strap_gang_i,
  input  wire logic          strap_pol_hi_i,
  output      logic [NP-1:0] port_power_enable_n_o,
  output      logic [NP-1:0] port_se0_o,
  output      logic [NP-1:0] port_suspend_o,
  output      logic [NP-1:0] led_green_o,
  output      logic [NP-1:0] led_amber_o,
  output      logic [NP-1:0] tt_route_o,
  output      logic [NP-1:0] tt_fwd_o,
  output      logic          status_change_o,
  output      logic          resume_up_o,
  output      logic          up_tx_block_o
);

  localparam logic [TMR_W-1:0] OC_END  = TMR_W'(OC_CYCLES - 1);
  localparam logic [TMR_W-1:0] RST_END = TMR_W'(RST_CYCLES - 1);

  typedef struct packed {
    logic [NP-1:0]              oc_s1;
    logic [NP-1:0]              oc_s2;
    logic [NP-1:0]              dp_s1;
    logic [NP-1:0]              dp_s2;
    logic [NP-1:0]              dm_s1;
    logic [NP-1:0]              dm_s2;
    logic [1:0]                 strap_s1;
    logic [1:0]                 strap_s2;
    logic [1:0]                 strap_cnt;
    logic                       gang;
    logic                       pol_hi;
    logic [6:0]                 addr;
    logic [7:0]                 cfg;
    logic                       hub_susp;
    logic                       mtt;
    logic                       manual;
    hdc_pst_t [NP-1:0]          pst;
    logic [NP-1:0]              power;
    logic [NP-1:0]              oc_flt;
    logic [NP-1:0]              armed;
    logic [NP-1:0]              ls;
    logic [NP-1:0][TMR_W-1:0]   rtmr;
    logic [NP-1:0][TMR_W-1:0]   otmr;
    logic [NP-1:0][CHG_W-1:0]   chg;
    logic [NP-1:0][1:0]         led;
    logic                       wake;
    logic                       blk;
    logic                       ack;
    logic [31:0]                dat;
  } hdc_state_t;

  hdc_state_t state_reg;
  hdc_state_t state_next;

  function automatic logic [31:0] bmask(input logic [3:0] sel);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int b = 0; b < 4; b++) begin
      m[b*8 +: 8] = {8{sel[b]}};
    end
    return m;
  endfunction

  function automatic logic [31:0] bmerge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  sel);
    return (old & ~bmask(sel)) | (nw & bmask(sel));
  endfunction

  logic        wr;
  logic        rd;
  logic [31:0] wmerged;
  hdc_cmd_t    cmd;
  logic [1:0]  cport;
  logic        oc_any;
  logic        evt_up;
  logic        se0;
  logic        idle;
  logic        kst;
  logic        hit;
  logic        pwr_hit;
  logic        port_oc;
  logic [31:0] stat;
  logic [31:0] chgw;
  logic [31:0] ledw;

  always_comb begin
    state_next = state_reg;
    state_next.ack = 1'b0;
    wr = wb_cyc_i & wb_stb_i & wb_we_i & ~state_reg.ack;
    rd = wb_cyc_i & wb_stb_i & ~wb_we_i & ~state_reg.ack;
    wmerged = 32'h0000_0000;
    cmd = CMD_NONE;
    cport = wb_dat_i[CMD_PORT_LSB +: 2];
    if (wr && wb_adr_i == ADR_CMD && wb_sel_i[0]) begin
      cmd = hdc_cmd_t'(wb_dat_i[2:0]);
    end
    se0 = 1'b0;
    idle = 1'b0;
    kst = 1'b0;
    hit = 1'b0;
    pwr_hit = 1'b0;
    port_oc = 1'b0;
    evt_up = 1'b0;
    stat = 32'h0000_0000;
    chgw = 32'h0000_0000;
    ledw = 32'h0000_0000;

    // Pin synchronisers
    state_next.oc_s1 = ~port_overcurrent_in_n_i;
    state_next.oc_s2 = state_reg.oc_s1;
    state_next.dp_s1 = port_dp_i;
    state_next.dp_s2 = state_reg.dp_s1;
    state_next.dm_s1 = port_dm_i;
    state_next.dm_s2 = state_reg.dm_s1;
    state_next.strap_s1 = {strap_pol_hi_i, strap_gang_i};
    state_next.strap_s2 = state_reg.strap_s1;

    // Straps are taken once, after the synchroniser has filled
    if (state_reg.strap_cnt != 2'h3) begin
      state_next.strap_cnt = state_reg.strap_cnt + 2'h1;
      if (state_reg.strap_cnt == 2'h2) begin
        state_next.gang = state_reg.strap_s2[0];
        state_next.pol_hi = state_reg.strap_s2[1];
      end
    end

    oc_any = |(state_reg.oc_s2 & state_reg.power);

    // Change bits: clear by write-one, set in the loop below wins
    for (int p = 0; p < NP; p++) begin
      chgw[p*ST_STRIDE +: CHG_W] = state_reg.chg[p];
    end
    if (wr && wb_adr_i == ADR_CHG) begin
      chgw = chgw & ~(wb_dat_i & bmask(wb_sel_i));
    end
    for (int p = 0; p < NP; p++) begin
      state_next.chg[p] = chgw[p*ST_STRIDE +: CHG_W];
    end

    for (int p = 0; p < NP; p++) begin
      se0 = ~state_reg.dp_s2[p] & ~state_reg.dm_s2[p];
      idle = state_reg.ls[p] ? (~state_reg.dp_s2[p] & state_reg.dm_s2[p])
                             : (state_reg.dp_s2[p] & ~state_reg.dm_s2[p]);
      kst = state_reg.ls[p] ? (state_reg.dp_s2[p] & ~state_reg.dm_s2[p])
                            : (~state_reg.dp_s2[p] & state_reg.dm_s2[p]);
      hit = (cport == 2'(p));
      pwr_hit = hit | state_reg.gang;
      port_oc = state_reg.gang ? oc_any : state_reg.oc_s2[p];

      // Overcurrent: report at once, cut power after the delay
      if (port_oc && state_reg.power[p] && !state_reg.oc_flt[p]) begin
        state_next.oc_flt[p] = 1'b1;
        state_next.chg[p][CH_OC] = 1'b1;
        state_next.otmr[p] = '0;
      end else if (state_reg.oc_flt[p] && state_reg.power[p]) begin
        state_next.otmr[p] = state_reg.otmr[p] + TMR_W'(1);
        if (state_reg.otmr[p] == OC_END) begin
          state_next.power[p] = 1'b0;
          state_next.pst[p] = PS_OFF;
        end
      end

      case (state_reg.pst[p])
        PS_OFF: begin
          state_next.armed[p] = 1'b0;
        end
        PS_DISC: begin
          if (!se0) begin
            state_next.pst[p] = PS_DIS;
            state_next.ls[p] = state_reg.dm_s2[p];
            state_next.chg[p][CH_CONN] = 1'b1;
          end
        end
        PS_DIS: begin
          if (se0) begin
            state_next.pst[p] = PS_DISC;
            state_next.chg[p][CH_CONN] = 1'b1;
          end
        end
        PS_RST: begin
          state_next.rtmr[p] = state_reg.rtmr[p] + TMR_W'(1);
          if (state_reg.rtmr[p] == RST_END) begin
            state_next.pst[p] = PS_EN;
            state_next.chg[p][CH_RST] = 1'b1;
          end
        end
        PS_EN: begin
          // Arming one cycle after enable keeps reset recovery clean
          if (!state_reg.armed[p]) begin
            state_next.armed[p] = 1'b1;
          end else if (eof2_i && se0) begin
            state_next.pst[p] = PS_DISC;
            state_next.armed[p] = 1'b0;
            state_next.chg[p][CH_CONN] = 1'b1;
            evt_up = 1'b1;
          end else if (eof2_i && !idle) begin
            state_next.pst[p] = PS_DIS;
            state_next.armed[p] = 1'b0;
            state_next.chg[p][CH_EN] = 1'b1;
            evt_up = 1'b1;
          end
        end
        PS_SUSP: begin
          if (se0) begin
            state_next.pst[p] = PS_DISC;
            state_next.chg[p][CH_CONN] = 1'b1;
            evt_up = 1'b1;
          end else if (kst) begin
            state_next.pst[p] = PS_EN;
            if (state_reg.hub_susp) begin
              state_next.wake = 1'b1;
            end else begin
              state_next.chg[p][CH_SUSP] = 1'b1;
            end
          end
        end
        default: begin
          state_next.pst[p] = PS_OFF;
        end
      endcase

      // Host requests override line events in the same cycle
      case (cmd)
        CMD_SET_PWR: begin
          if (pwr_hit && state_reg.cfg != 8'h00) begin
            state_next.power[p] = 1'b1;
            state_next.oc_flt[p] = 1'b0;
            if (!state_reg.power[p]) begin
              state_next.pst[p] = PS_DISC;
            end
          end
        end
        CMD_CLR_PWR: begin
          if (pwr_hit) begin
            state_next.power[p] = 1'b0;
            state_next.pst[p] = PS_OFF;
          end
        end
        CMD_SET_RST: begin
          if (hit && state_reg.pst[p] != PS_OFF && state_reg.pst[p] != PS_DISC) begin
            state_next.pst[p] = PS_RST;
            state_next.rtmr[p] = '0;
            state_next.armed[p] = 1'b0;
          end
        end
        CMD_CLR_EN: begin
          if (hit && (state_reg.pst[p] == PS_EN || state_reg.pst[p] == PS_SUSP)) begin
            state_next.pst[p] = PS_DIS;
            state_next.armed[p] = 1'b0;
          end
        end
        CMD_SET_SUS: begin
          if (hit && state_reg.pst[p] == PS_EN) begin
            state_next.pst[p] = PS_SUSP;
          end
        end
        CMD_CLR_SUS: begin
          if (hit && state_reg.pst[p] == PS_SUSP) begin
            state_next.pst[p] = PS_EN;
          end
        end
        default: begin
        end
      endcase

      // Faulted port stays dark until a fresh power request
      if (state_reg.oc_flt[p] && !state_reg.power[p] && cmd != CMD_SET_PWR) begin
        state_next.power[p] = 1'b0;
      end

      if (state_reg.cfg == 8'h00) begin
        state_next.power[p] = 1'b0;
        state_next.pst[p] = PS_OFF;
        state_next.armed[p] = 1'b0;
      end

      stat[p*ST_STRIDE + ST_POWER] = state_reg.power[p];
      stat[p*ST_STRIDE + ST_CONN] = state_reg.pst[p] > PS_DISC;
      stat[p*ST_STRIDE + ST_EN] = state_reg.pst[p] >= PS_EN;
      stat[p*ST_STRIDE + ST_SUSP] = state_reg.pst[p] == PS_SUSP;
      stat[p*ST_STRIDE + ST_OC] = state_reg.oc_flt[p];
      stat[p*ST_STRIDE + ST_RST] = state_reg.pst[p] == PS_RST;
      stat[p*ST_STRIDE + ST_LS] = state_reg.ls[p];
      stat[p*ST_STRIDE + ST_HS] = port_hs_i[p];
      ledw[p*2 +: 2] = state_reg.led[p];
    end

    if (!state_reg.hub_susp) begin
      state_next.wake = 1'b0;
    end
    state_next.blk = rpt_up_active_i & evt_up;

    // Register writes
    if (wr) begin
      case (wb_adr_i)
        ADR_CTRL: begin
          wmerged = bmerge({29'h0, state_reg.manual, state_reg.mtt, state_reg.hub_susp},
                           wb_dat_i, wb_sel_i);
          state_next.hub_susp = wmerged[CTRL_SUSP];
          state_next.mtt = wmerged[CTRL_MTT];
          state_next.manual = wmerged[CTRL_MAN];
        end
        ADR_DEV: begin
          wmerged = bmerge({16'h0, state_reg.cfg, 1'b0, state_reg.addr},
                           wb_dat_i, wb_sel_i);
          state_next.addr = wmerged[6:0];
          state_next.cfg = wmerged[DEV_CFG_LSB +: 8];
          if (wmerged[DEV_CFG_LSB +: 8] != state_reg.cfg) begin
            state_next.mtt = 1'b0;
          end
        end
        ADR_LED: begin
          wmerged = bmerge(ledw, wb_dat_i, wb_sel_i);
          for (int p = 0; p < NP; p++) begin
            state_next.led[p] = wmerged[p*2 +: 2];
          end
        end
        default: begin
        end
      endcase
    end

    if (usb_bus_reset_i) begin
      state_next.addr = 7'h00;
      state_next.cfg = 8'h00;
      state_next.mtt = 1'b0;
      state_next.hub_susp = 1'b0;
    end

    // Bus answer: one cycle after the request, unmapped reads zero
    if (wr || rd) begin
      state_next.ack = 1'b1;
      case (wb_adr_i)
        ADR_CTRL: state_next.dat = {29'h0, state_reg.manual, state_reg.mtt,
                                    state_reg.hub_susp};
        ADR_DEV: state_next.dat = {16'h0, state_reg.cfg, 1'b0, state_reg.addr};
        ADR_STAT: state_next.dat = stat;
        ADR_CHG: state_next.dat = chgw;
        ADR_LED: state_next.dat = ledw;
        ADR_HCHAR: begin
          state_next.dat = 32'h0000_0000;
          state_next.dat[HCHAR_IND_BIT] = 1'b1;
          state_next.dat[HCHAR_IND_PWR] = ~state_reg.gang;
          state_next.dat[HCHAR_IND_OC] = ~state_reg.gang;
        end
        default: state_next.dat = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  logic [NP-1:0] ls_route;

  always_comb begin
    ls_route = {NP{up_hs_i}} & ~port_hs_i;
    tt_route_o = ls_route;
    // Single mode shares one translator, so every slow port hears it
    if (state_reg.mtt) begin
      tt_fwd_o = tt_target_i & ls_route;
    end else begin
      tt_fwd_o = (|(tt_target_i & ls_route)) ? ls_route : '0;
    end
    for (int p = 0; p < NP; p++) begin
      port_power_enable_n_o[p] = state_reg.pol_hi ? state_reg.power[p]
                                                  : ~state_reg.power[p];
      port_se0_o[p] = (state_reg.cfg == 8'h00) | (state_reg.pst[p] == PS_RST);
      port_suspend_o[p] = state_reg.pst[p] == PS_SUSP;
      if (state_reg.hub_susp) begin
        led_green_o[p] = 1'b0;
        led_amber_o[p] = 1'b0;
      end else if (state_reg.manual) begin
        led_green_o[p] = state_reg.led[p] == LED_GREEN;
        led_amber_o[p] = state_reg.led[p] == LED_AMBER;
      end else begin
        led_green_o[p] = state_reg.pst[p] == PS_EN;
        led_amber_o[p] = state_reg.oc_flt[p] | (state_reg.pst[p] == PS_DIS);
      end
    end
  end

  assign wb_dat_o        = state_reg.dat;
  assign wb_ack_o        = state_reg.ack;
  assign status_change_o = (|state_reg.chg) & ~state_reg.hub_susp;
  assign resume_up_o     = state_reg.wake;
  assign up_tx_block_o   = state_reg.blk;

endmodule

// file: verif/hdc_sva.sv
// Assertions on the port control top-level ports.
// Assumes binding into hdc_port_ctrl, one clock domain.
`timescale 1ns/100ps
module hdc_sva
  import hdc_pkg::*;
#(
  parameter int NP        = NPORT,
  parameter int OC_CYCLES = OC_CYC_DEF
) (
  input wire logic          clk_i,
  input wire logic          rst_i,
  input wire logic [7:0]    wb_adr_i,
  input wire logic          wb_we_i,
  input wire logic          wb_cyc_i,
  input wire logic          wb_stb_i,
  input wire logic          wb_ack_o,
  input wire logic          usb_bus_reset_i,
  input wire logic          up_hs_i,
  input wire logic [NP-1:0] port_hs_i,
  input wire logic          rpt_up_active_i,
  input wire logic [NP-1:0] port_overcurrent_in_n_i,
  input wire logic          strap_pol_hi_i,
  input wire logic [NP-1:0] port_power_enable_n_o,
  input wire logic [NP-1:0] port_se0_o,
  input wire logic [NP-1:0] tt_route_o,
  input wire logic          up_tx_block_o
);
  // Slack covers the input synchroniser and detect stage
  localparam int OC_LO = OC_CYCLES;
  localparam int OC_HI = OC_CYCLES + OC_CYCLES / 3 + 6;
  logic       on0;
  logic       on1;
  logic       cmd_wr;
  logic [7:0] oc_cnt;
  assign on0    = port_power_enable_n_o[0] == strap_pol_hi_i;
  assign on1    = port_power_enable_n_o[1] == strap_pol_hi_i;
  assign cmd_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == ADR_CMD;
  always_ff @(posedge clk_i) begin
    if (rst_i || port_overcurrent_in_n_i[1]) begin
      oc_cnt <= 8'h00;
    end else if (oc_cnt != 8'hFF) begin
      oc_cnt <= oc_cnt + 8'h01;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_oc_hit;
    $fell(port_overcurrent_in_n_i[1]) && on1;
  endsequence
  sequence s_cmd_seen;
    $past(cmd_wr) || $past(cmd_wr, 2);
  endsequence
  AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_RST_SE0: assert property ($fell(rst_i) |-> port_se0_o == {NP{1'h1}})
    else $error("ports not in SE0 after reset");
  AST_BUS_RST: assert property (usb_bus_reset_i |-> ##[1:3] port_se0_o == {NP{1'h1}})
    else $error("bus reset left ports released");
  AST_ROUTE: assert property (tt_route_o == ({NP{up_hs_i}} & ~port_hs_i))
    else $error("translator routing wrong");
  AST_OC_EARLY: assert property (oc_cnt != 8'h00 && oc_cnt < OC_LO |-> on1)
    else $error("power dropped too early");
  AST_OC_LATE: assert property (s_oc_hit |-> ##[OC_LO:OC_HI] !on1)
    else $error("power dropped too late");
  AST_PWR_CMD: assert property ($rose(on0) |-> s_cmd_seen)
    else $error("power rose without command");
  AST_BLOCK: assert property (up_tx_block_o |-> $past(rpt_up_active_i))
    else $error("block without repeater activity");
endmodule
bind hdc_port_ctrl hdc_sva #(.NP(NP), .OC_CYCLES(OC_CYCLES)) hdc_sva_i (.*);

// file: verif/hdc_far_model.sv
// Downstream devices and power switches facing the port control block.
// Assumes the bench decodes power state and requests attach, K and faults.
`timescale 1ns/100ps
module hdc_far_model (
  input  wire logic       clk_i,
  input  wire logic [3:0] hub_se0_i,
  input  wire logic [3:0] pwr_on_i,
  input  wire logic [3:0] attach_i,
  input  wire logic [3:0] kstate_i,
  input  wire logic [3:0] fault_i,
  output      logic [3:0] dp_o,
  output      logic [3:0] dm_o,
  output      logic [3:0] oc_n_o
);
  // Unpowered or hub-driven lines sit at SE0 through the pull-downs
  logic [3:0] live = 4'h0;
  always @(posedge clk_i) begin
    live <= attach_i & pwr_on_i & ~hub_se0_i;
  end
  assign dp_o   = live & ~kstate_i;
  assign dm_o   = live & kstate_i;
  // Switch flags a fault only while it supplies the port
  assign oc_n_o = ~(fault_i & pwr_on_i);
endmodule

// file: verif/tb_hub_downstream_port_control.sv
// Self-checking bench for the hub downstream port control block.
// Assumes the design, checker and far-side model are compiled first.
`timescale 1ns/100ps
module tb_hub_downstream_port_control
  import hdc_pkg::*;
;
  // Short counts keep the run brief
  localparam int OC   = 20;
  localparam int RSTC = 10;
  logic        clk_i = 1'h0, rst_i = 1'h1;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  logic        wb_we_i = 1'h0, wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_ack_o;
  logic [3:0]  wb_sel_i = 4'hF;
  logic        usb_bus_reset_i = 1'h0, eof2_i = 1'h0, up_hs_i = 1'h0;
  logic        rpt_up_active_i = 1'h0, strap_gang_i = 1'h0, strap_pol_hi_i = 1'h1;
  logic        status_change_o, resume_up_o, up_tx_block_o;
  logic [3:0]  port_hs_i = 4'h0, tt_target_i = 4'h0;
  logic [3:0]  port_dp_i, port_dm_i, port_overcurrent_in_n_i;
  logic [3:0]  port_power_enable_n_o, port_se0_o, port_suspend_o;
  logic [3:0]  led_green_o, led_amber_o, tt_route_o, tt_fwd_o;
  logic [3:0]  attach = 4'h3, kst = 4'h0, flt = 4'h0;
  int          failures = 0, check_count = 0;

  hdc_port_ctrl #(.OC_CYCLES(OC), .RST_CYCLES(RSTC)) hdc_port_ctrl_i (.*);
  hdc_far_model hdc_far_model_i (
    .clk_i     (clk_i),
    .hub_se0_i (port_se0_o),
    .pwr_on_i  (~(port_power_enable_n_o ^ {4{strap_pol_hi_i}})),
    .attach_i  (attach),
    .kstate_i  (kst),
    .fault_i   (flt),
    .dp_o      (port_dp_i),
    .dm_o      (port_dm_i),
    .oc_n_o    (port_overcurrent_in_n_i)
  );
  always #4 clk_i = ~clk_i;

  task automatic end_sim;
    if (failures == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic xfer(input logic [7:0] a, input logic [31:0] d, input logic w);
    int n;
    n = 0;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_we_i  <= w;
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'h1 && n < 50);
    if (n == 50) failures++;
    q = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    wb_we_i  <= 1'h0;
    @(posedge clk_i);
  endtask
  task automatic cmd(input int p, input hdc_cmd_t k);
    xfer(ADR_CMD, {26'h0, p[1:0], 1'h0, k}, 1'h1);
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input int b, input logic e);
    xfer(a, 32'h0, 1'h0);
    chk(nm, q[b], e);
  endtask
  task automatic prst;
    cmd(0, CMD_SET_RST);
    tick(RSTC + 8);
    xfer(ADR_CHG, 32'hFFFF_FFFF, 1'h1);
  endtask

  initial begin
    tick(5);
    rst_i <= 1'h0;
    tick(4);
    chk("se0", port_se0_o, 4'hF);
    chk("pwr", port_power_enable_n_o, 4'h0);
    rchk("ind", ADR_HCHAR, HCHAR_IND_BIT, 1'h1);
    xfer(8'h1C, 32'h0, 1'h0);
    chk("unmapped", q, 32'h0);
    cmd(0, CMD_SET_PWR);
    chk("pwr_uncfg", port_power_enable_n_o, 4'h0);
    xfer(ADR_DEV, 32'h0000_0105, 1'h1);
    chk("se0_cfg", port_se0_o, 4'h0);
    rchk("single_tt", ADR_CTRL, CTRL_MTT, 1'h0);
    cmd(0, CMD_SET_PWR);
    cmd(1, CMD_SET_PWR);
    chk("pwr_on", port_power_enable_n_o, 4'h3);
    tick(6);
    chk("stchg", status_change_o, 1'h1);
    rchk("conn", ADR_STAT, ST_STRIDE + ST_CONN, 1'h1);
    chk("amber", led_amber_o, 4'h3);
    cmd(0, CMD_SET_RST);
    chk("rst_se0", port_se0_o, 4'h1);
    tick(RSTC + 8);
    rchk("enabled", ADR_STAT, ST_EN, 1'h1);
    chk("green", led_green_o, 4'h1);
    xfer(ADR_CTRL, 32'h4, 1'h1);
    xfer(ADR_LED, {30'h0, LED_AMBER}, 1'h1);
    chk("manual", {led_green_o[0], led_amber_o[0]}, 2'h1);
    xfer(ADR_CTRL, 32'h0, 1'h1);
    rpt_up_active_i <= 1'h1;
    kst <= 4'h1;
    tick(5);
    eof2_i <= 1'h1;
    tick(1);
    eof2_i <= 1'h0;
    kst <= 4'h0;
    tick(1);
    chk("block", up_tx_block_o, 1'h1);
    tick(3);
    rchk("babble", ADR_STAT, ST_EN, 1'h0);
    prst();
    cmd(0, CMD_CLR_EN);
    rchk("clr_en", ADR_STAT, ST_EN, 1'h0);
    prst();
    cmd(0, CMD_SET_SUS);
    chk("susp", port_suspend_o, 4'h1);
    cmd(0, CMD_CLR_SUS);
    chk("unsusp", port_suspend_o, 4'h0);
    cmd(0, CMD_SET_SUS);
    kst <= 4'h1;
    tick(6);
    rchk("wake", ADR_CHG, CH_SUSP, 1'h1);
    kst <= 4'h0;
    // Let the line synchroniser drain the K state first
    tick(3);
    cmd(0, CMD_SET_SUS);
    xfer(ADR_CTRL, 32'h1, 1'h1);
    chk("leds_off", {led_green_o, led_amber_o}, 8'h0);
    kst <= 4'h1;
    tick(6);
    chk("resume_up", resume_up_o, 1'h1);
    kst <= 4'h0;
    xfer(ADR_CTRL, 32'h0, 1'h1);
    up_hs_i <= 1'h1;
    tick(1);
    chk("route", tt_route_o, 4'hF);
    tt_target_i <= 4'h1;
    tick(1);
    chk("fwd_single", tt_fwd_o, 4'hF);
    xfer(ADR_CTRL, 32'h2, 1'h1);
    chk("fwd_multi", tt_fwd_o, 4'h1);
    flt <= 4'h2;
    tick(8);
    rchk("oc", ADR_STAT, ST_STRIDE + ST_OC, 1'h1);
    tick(OC);
    chk("oc_off", port_power_enable_n_o[1], 1'h0);
    flt <= 4'h0;
    tick(8);
    chk("oc_hold", port_power_enable_n_o[1], 1'h0);
    cmd(1, CMD_SET_PWR);
    chk("repower", port_power_enable_n_o[1], 1'h1);
    usb_bus_reset_i <= 1'h1;
    tick(1);
    usb_bus_reset_i <= 1'h0;
    tick(3);
    chk("bus_rst", port_se0_o, 4'hF);
    rchk("cfg0", ADR_DEV, DEV_CFG_LSB, 1'h0);
    // Second power-up with ganged, low-enabled switches
    strap_gang_i   <= 1'h1;
    strap_pol_hi_i <= 1'h0;
    rst_i          <= 1'h1;
    tick(5);
    rst_i <= 1'h0;
    tick(4);
    chk("pwr_lo_off", port_power_enable_n_o, 4'hF);
    xfer(ADR_DEV, 32'h0000_0105, 1'h1);
    cmd(2, CMD_SET_PWR);
    chk("gang_on", port_power_enable_n_o, 4'h0);
    end_sim();
  end

  initial begin
    tick(3000);
    failures++;
    end_sim();
  end
endmodule
